/* File: verilog/uftsr_pkg.sv */
/*
  Package for the UART FIFO test and status register block: offsets, fields, resets.
  Assumes a 32-bit register port with byte offsets as the register addresses.
*/
package uftsr_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          FIFO_DEPTH      = 16;
  localparam int          LVL_W           = 5;
  localparam int          PTR_W           = 4;
  localparam int          ENTRY_W         = 10;
  // Register offsets.
  localparam logic [7:0]  OFF_TEST_ACCESS = 8'h70;
  localparam logic [7:0]  OFF_TX_READ     = 8'h74;
  localparam logic [7:0]  OFF_RX_TWRITE   = 8'h78;
  localparam logic [7:0]  OFF_STATUS      = 8'h7c;
  localparam logic [7:0]  OFF_TX_LEVEL    = 8'h80;
  localparam logic [7:0]  OFF_RX_LEVEL    = 8'h84;
  localparam logic [7:0]  OFF_SOFT_RESET  = 8'h88;
  localparam logic [7:0]  OFF_RTS_ALIAS   = 8'h8c;
  localparam logic [7:0]  OFF_QUEUE_CTRL  = 8'h08;
  localparam logic [7:0]  OFF_MODEM_CTRL  = 8'h10;
  localparam logic [7:0]  OFF_RX_BUF      = 8'h00;
  localparam logic [7:0]  OFF_TX_PUSH     = 8'h04;
  localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h0c;
  localparam logic [7:0]  OFF_IRQ_ENABLE  = 8'h14;
  localparam logic [7:0]  OFF_IRQ_CLEAR   = 8'h18;
  // Field positions.
  localparam int          BIT_FE          = 9;
  localparam int          BIT_PE          = 8;
  localparam int          ST_RX_FULL      = 4;
  localparam int          ST_RX_NEMPTY    = 3;
  localparam int          ST_TX_EMPTY     = 2;
  localparam int          ST_TX_NFULL     = 1;
  localparam int          ST_BUSY         = 0;
  localparam int          SR_TX_FLUSH     = 2;
  localparam int          SR_RX_FLUSH     = 1;
  localparam int          SR_UART_RESET   = 0;
  localparam int          QC_ENABLE       = 0;
  localparam int          QC_RX_FLUSH     = 1;
  localparam int          QC_TX_FLUSH     = 2;
  localparam int          MC_RTS          = 1;
  localparam int          IRQ_W           = 3;
  localparam int          IRQ_RX_PUSH     = 0;
  localparam int          IRQ_RX_FULL     = 1;
  localparam int          IRQ_TX_EMPTY    = 2;
  // Reset values.
  localparam logic [31:0] RESET_VAL       = 32'h0000_0000;
endpackage

/* File: verilog/uftsr_top.sv */
/*
  UART FIFO test write, status, fill level, soft reset and request-to-send alias logic.
  Assumes a single-cycle register port master and a serial engine outside that pops
  the transmit FIFO and reports a busy level; one clock only.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - Test write pushes byte into receive FIFO.
// - FIFOs off: test write fills receive buffer.
// - Bits 9 and 8 store framing, parity errors.
// - Test write effective only in test access mode.
// - Status bit 4 shows receive FIFO full.
// - Status bit 3 shows receive FIFO nonempty.
// - Status bit 2 shows transmit FIFO empty.
// - Status bit 1 shows transmit FIFO not full.
// - Status bit 0 shows serial transfer busy.
// - Transmit level reports transmit FIFO entries.
// - Receive level reports receive FIFO entries.
// - Soft reset bit 2 flushes transmit FIFO.
// - Soft reset bit 1 flushes receive FIFO.
// - Soft reset bit 0 resets whole UART.
// - Whole reset covers every clock domain.
// - Alias bit 0 is modem control RTS.
// - Test mode allows software transmit FIFO reads.
module uftsr_top
  import uftsr_pkg::*;
(
  input  wire logic                        CLK,
  input  wire logic                        RST_N,
  input  wire logic [uftsr_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [uftsr_pkg::DATA_W-1:0] WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output logic      [uftsr_pkg::DATA_W-1:0] RDATA,
  input  wire logic                        SER_BUSY,
  input  wire logic                        SER_TX_POP,
  output logic      [7:0]                  SER_TX_DATA,
  output logic                             SER_TX_VALID,
  output logic                             RTS_N,
  output logic                             IRQ
);
  import uftsr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset: the pin and the soft reset both assert at once and release on the clock.

  logic                rst_s1_q;
  logic                rst_s2_q;
  logic                soft_rst_q;
  wire                 rst_src_n = RST_N & ~soft_rst_q;
  wire                 rst_n     = rst_s2_q;

  // Only one clock domain exists, so this one synchroniser covers all flops but the soft reset flop and the unreset FIFO memories.
  // The soft reset joins the pin ahead of the flops: assertion is immediate, and release
  // always waits two clock edges, so no register leaves reset on a glitch.
  always_ff @(posedge CLK or negedge rst_src_n) begin
    if (!rst_src_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decode.
  // Addresses match in full; a write to a read-only offset changes nothing.

  wire wr_access  = WR & (ADDR == OFF_TEST_ACCESS);
  wire rd_txread  = RD & (ADDR == OFF_TX_READ);
  wire wr_rxtest  = WR & (ADDR == OFF_RX_TWRITE);
  wire wr_soft    = WR & (ADDR == OFF_SOFT_RESET);
  wire wr_rts     = WR & (ADDR == OFF_RTS_ALIAS);
  wire wr_qctrl   = WR & (ADDR == OFF_QUEUE_CTRL);
  wire wr_mctrl   = WR & (ADDR == OFF_MODEM_CTRL);
  wire rd_rxbuf   = RD & (ADDR == OFF_RX_BUF);
  wire wr_txpush  = WR & (ADDR == OFF_TX_PUSH);
  wire wr_irq_en  = WR & (ADDR == OFF_IRQ_ENABLE);
  wire wr_irq_clr = WR & (ADDR == OFF_IRQ_CLEAR);

  ////////////////////////////////////////////////////////////////////////////////
  // Control bits.

  logic                test_mode_q;
  logic                fifo_en_q;
  logic [7:0]          mctrl_q;
  logic [IRQ_W-1:0]    irq_en_q;

  // The alias and the full modem control write share one bit, so no read-modify-write.
  wire       rts_d   = wr_rts ? WDATA[0] : wr_mctrl ? WDATA[MC_RTS] : mctrl_q[MC_RTS];
  wire [7:0] mctrl_d = wr_mctrl ? {WDATA[7:2], rts_d, WDATA[0]}
                                : {mctrl_q[7:2], rts_d, mctrl_q[0]};

  // Test access mode opens the software write into the receive FIFO and the software read of the transmit FIFO.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      test_mode_q <= 1'b0;
    end else if (wr_access) begin
      test_mode_q <= WDATA[0];
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      fifo_en_q <= 1'b0;
    end else if (wr_qctrl) begin
      fifo_en_q <= WDATA[QC_ENABLE];
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      mctrl_q <= RESET_VAL[7:0];
    end else begin
      mctrl_q <= mctrl_d;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_q <= RESET_VAL[IRQ_W-1:0];
    end else if (wr_irq_en) begin
      irq_en_q <= WDATA[IRQ_W-1:0];
    end
  end

  // The soft reset pulse lasts one cycle: the write strobe is gone by the next edge.
  // Its flop sits on the pin reset alone, so the pulse cannot cut itself short.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_soft & WDATA[SR_UART_RESET];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive FIFO, with the single buffer as a separate register read when FIFOs are off.

  logic [ENTRY_W-1:0]  rx_mem [FIFO_DEPTH];
  logic [PTR_W-1:0]    rx_wp_q;
  logic [PTR_W-1:0]    rx_rp_q;
  logic [LVL_W-1:0]    rx_lvl_q;
  logic [ENTRY_W-1:0]  rx_buf_q;

  wire rx_flush  = (wr_soft & WDATA[SR_RX_FLUSH]) | (wr_qctrl & WDATA[QC_RX_FLUSH]);
  wire rx_full   = (rx_lvl_q == LVL_W'(FIFO_DEPTH));
  wire rx_push   = wr_rxtest & test_mode_q & fifo_en_q & ~rx_full;
  wire rx_pop    = rd_rxbuf & fifo_en_q & (rx_lvl_q != '0);
  wire buf_load  = wr_rxtest & test_mode_q & ~fifo_en_q;
  wire [ENTRY_W-1:0] rx_entry = {WDATA[BIT_FE], WDATA[BIT_PE], WDATA[7:0]};

  always_ff @(posedge CLK) begin
    if (rx_push) rx_mem[rx_wp_q] <= rx_entry;
  end

  // Next values; a flush outranks a push or a pop in the same cycle.
  // Pointers wrap on their own width, which equals the depth of sixteen.
  wire [PTR_W-1:0] rx_wp_d  = rx_flush ? '0 : rx_wp_q + PTR_W'(rx_push);
  wire [PTR_W-1:0] rx_rp_d  = rx_flush ? '0 : rx_rp_q + PTR_W'(rx_pop);
  wire [LVL_W-1:0] rx_lvl_d = rx_flush ? '0 : rx_lvl_q + LVL_W'(rx_push) - LVL_W'(rx_pop);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_wp_q <= '0;
    end else begin
      rx_wp_q <= rx_wp_d;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_rp_q <= '0;
    end else begin
      rx_rp_q <= rx_rp_d;
    end
  end

  // The level moves in the cycle of the push or pop, so the next bus read sees it.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_lvl_q <= '0;
    end else begin
      rx_lvl_q <= rx_lvl_d;
    end
  end

  // The single buffer keeps its byte through a flush, as a holding register would.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_buf_q <= '0;
    end else if (buf_load) begin
      rx_buf_q <= rx_entry;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO: software pushes, the serial engine or a test-mode read pops.

  logic [7:0]          tx_mem [FIFO_DEPTH];
  logic [PTR_W-1:0]    tx_wp_q;
  logic [PTR_W-1:0]    tx_rp_q;
  logic [LVL_W-1:0]    tx_lvl_q;

  wire tx_flush  = (wr_soft & WDATA[SR_TX_FLUSH]) | (wr_qctrl & WDATA[QC_TX_FLUSH]);
  wire tx_full   = (tx_lvl_q == LVL_W'(FIFO_DEPTH));
  wire tx_empty  = (tx_lvl_q == '0);
  wire tx_push   = wr_txpush & ~tx_full;
  // In test mode the serial side stops popping so software sees every entry.
  wire tx_pop    = ~tx_empty & (test_mode_q ? rd_txread : SER_TX_POP);

  always_ff @(posedge CLK) begin
    if (tx_push) tx_mem[tx_wp_q] <= WDATA[7:0];
  end

  // Next values; a flush outranks a push or a pop in the same cycle.
  wire [PTR_W-1:0] tx_wp_d  = tx_flush ? '0 : tx_wp_q + PTR_W'(tx_push);
  wire [PTR_W-1:0] tx_rp_d  = tx_flush ? '0 : tx_rp_q + PTR_W'(tx_pop);
  wire [LVL_W-1:0] tx_lvl_d = tx_flush ? '0 : tx_lvl_q + LVL_W'(tx_push) - LVL_W'(tx_pop);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_wp_q <= '0;
    end else begin
      tx_wp_q <= tx_wp_d;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_rp_q <= '0;
    end else begin
      tx_rp_q <= tx_rp_d;
    end
  end

  // The level counts test-mode reads as pops, so software can watch it drain.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_lvl_q <= '0;
    end else begin
      tx_lvl_q <= tx_lvl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, enable, write-one-to-clear; a set beats a clear.

  logic [IRQ_W-1:0]    irq_st_q;
  // A level event counts only if the level truly moves: a push and a pop cancel.
  wire  [IRQ_W-1:0]    irq_set = {tx_pop & ~tx_push & (tx_lvl_q == LVL_W'(1)),
                                  rx_push & ~rx_pop & (rx_lvl_q == LVL_W'(FIFO_DEPTH - 1)),
                                  rx_push | buf_load};
  wire  [IRQ_W-1:0]    irq_clr = wr_irq_clr ? WDATA[IRQ_W-1:0] : '0;

  // A clear that meets a new event leaves the bit set, so no event is lost.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data and registered outputs.

  wire [4:0] status = {rx_full, (rx_lvl_q != '0), tx_empty, ~tx_full, SER_BUSY};

  // Unmapped offsets and write-only registers read as zero.
  logic [DATA_W-1:0] rdata_d;
  always_comb begin
    rdata_d = '0;
    if (RD) begin
      unique case (ADDR)
        OFF_TEST_ACCESS: rdata_d = {31'h0, test_mode_q};
        OFF_TX_READ:     rdata_d = test_mode_q ? {24'h0, tx_mem[tx_rp_q]} : '0;
        OFF_STATUS:      rdata_d = {27'h0, status};
        OFF_TX_LEVEL:    rdata_d = {27'h0, tx_lvl_q};
        OFF_RX_LEVEL:    rdata_d = {27'h0, rx_lvl_q};
        OFF_RTS_ALIAS:   rdata_d = {31'h0, mctrl_q[MC_RTS]};
        OFF_MODEM_CTRL:  rdata_d = {24'h0, mctrl_q};
        OFF_QUEUE_CTRL:  rdata_d = {31'h0, fifo_en_q};
        OFF_IRQ_STATUS:  rdata_d = {29'h0, irq_st_q};
        OFF_IRQ_ENABLE:  rdata_d = {29'h0, irq_en_q};
        OFF_RX_BUF:      rdata_d = fifo_en_q ? {22'h0, rx_mem[rx_rp_q]}
                                             : {22'h0, rx_buf_q};
        default:         rdata_d = '0;
      endcase
    end
  end

  // Named next values keep the output flops plain, and every output leaves a flop.
  wire [7:0] tx_head_d  = tx_mem[tx_rp_q];
  wire       tx_valid_d = ~tx_empty & ~test_mode_q;
  wire       irq_d      = |(irq_st_q & irq_en_q);

  // Read data stand only in the cycle after the strobe, and are zero otherwise.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= '0;
    end else begin
      RDATA <= rdata_d;
    end
  end

  // The head reaches the serial side a cycle late, so the engine pops on valid.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      SER_TX_DATA <= '0;
    end else begin
      SER_TX_DATA <= tx_head_d;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      SER_TX_VALID <= 1'b0;
    end else begin
      SER_TX_VALID <= tx_valid_d;
    end
  end

  // The pin is active low, so it idles high while the block is in reset.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RTS_N <= 1'b1;
    end else begin
      RTS_N <= ~mctrl_q[MC_RTS];
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= irq_d;
    end
  end

endmodule // uftsr_top

/* File: bench/uftsr_assertions.sv */
/*
  Port checker for the UART FIFO test and status block.
  Assumes one clock CLK and the raw active-low RST_N as the disable.
*/
`timescale 1ns/1ps
module uftsr_chk
  import uftsr_pkg::*;
(
  input wire logic                         CLK,
  input wire logic                         RST_N,
  input wire logic [uftsr_pkg::ADDR_W-1:0] ADDR,
  input wire logic [uftsr_pkg::DATA_W-1:0] WDATA,
  input wire logic                         WR,
  input wire logic                         RD,
  input wire logic [uftsr_pkg::DATA_W-1:0] RDATA,
  input wire logic                         SER_BUSY,
  input wire logic                         SER_TX_VALID,
  input wire logic                         RTS_N,
  input wire logic                         IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire st_rd = RD && ADDR == OFF_STATUS;
  //////////////////////////////////////////////////////////////////
  a_rdata_quiet: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data not idle");
  a_busy_status: assert property (st_rd |=> RDATA[ST_BUSY] == $past(SER_BUSY))
    else $error("busy bit wrong");
  a_rx_flags_agree: assert property (st_rd |=> !RDATA[ST_RX_FULL] || RDATA[ST_RX_NEMPTY])
    else $error("rx flags disagree");
  a_tx_flags_agree: assert property (st_rd |=> (!RDATA[ST_TX_EMPTY] || RDATA[ST_TX_NFULL])
    && RDATA[31:5] == 27'h0)
    else $error("tx flags disagree");
  a_tx_level_range: assert property (RD && ADDR == OFF_TX_LEVEL |=> RDATA <= 32'h10)
    else $error("tx level out of range");
  a_rx_level_range: assert property (RD && ADDR == OFF_RX_LEVEL |=> RDATA <= 32'h10)
    else $error("rx level out of range");
  a_rts_readback: assert property (RD && ADDR == OFF_RTS_ALIAS |=> RDATA == {31'h0, ~RTS_N})
    else $error("rts alias differs from pin");
  a_soft_reset: assert property (WR && ADDR == OFF_SOFT_RESET && WDATA[SR_UART_RESET]
    |-> ##[1:3] (RTS_N && !IRQ && !SER_TX_VALID))
    else $error("soft reset not applied");
  c_rx_full: cover property (st_rd ##1 RDATA[ST_RX_FULL]);
  c_irq: cover property (IRQ);
  c_soft_reset: cover property (WR && ADDR == OFF_SOFT_RESET);
endmodule // uftsr_chk

bind uftsr_top uftsr_chk u_chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .SER_BUSY(SER_BUSY), .SER_TX_VALID(SER_TX_VALID),
  .RTS_N(RTS_N), .IRQ(IRQ));

/* File: bench/testbench.sv */
/*
  Self-checking bench for the UART FIFO test and status block.
  Assumes the single-cycle register port described for the block.
*/
`timescale 1ns/1ps
module testbench;
  import uftsr_pkg::*;
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic        busy  = 1'b0;
  logic        pop   = 1'b0;
  logic [7:0]  addr  = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        rts_n;
  logic        irq;
  int          fail_count = 0;
  int          num_checks = 0;

  uftsr_top DUT (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SER_BUSY(busy), .SER_TX_POP(pop), .SER_TX_DATA(tx_data),
    .SER_TX_VALID(tx_valid), .RTS_N(rts_n), .IRQ(irq));

  always #25 clk = ~clk;
  //////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // Each access starts on its own edge, so strobes never see two assignments at once.
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(logic [7:0] a, logic [31:0] e, string n);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp(n, e, rdata);
  endtask

  task automatic pin(string n, logic [31:0] e);
    logic [31:0] seen;
    @(posedge clk);
    #1 seen = n == "irq" ? {31'h0, irq} : n == "rts" ? {31'h0, rts_n}
            : n == "valid" ? {31'h0, tx_valid} : {24'h0, tx_data};
    cmp(n, e, seen);
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(OFF_STATUS, 32'h6, "status");
    rd_reg(OFF_TX_LEVEL, 32'h0, "tx level");
    rd_reg(8'h40, 32'h0, "unmapped");
    @(posedge clk) busy <= 1'b1;
    rd_reg(OFF_STATUS, 32'h7, "status");
    @(posedge clk) busy <= 1'b0;
    wr_reg(OFF_QUEUE_CTRL, 32'h1);
    wr_reg(OFF_RX_TWRITE, 32'h3a5);
    rd_reg(OFF_RX_LEVEL, 32'h0, "rx level");
    wr_reg(OFF_TEST_ACCESS, 32'h1);
    for (int i = 0; i < 17; i++) begin
      wr_reg(OFF_RX_TWRITE, {22'h0, i[1:0], 8'ha0 + i[7:0]});
      if (i == 0) rd_reg(OFF_STATUS, 32'h0e, "status");
    end
    rd_reg(OFF_STATUS, 32'h1e, "status");
    rd_reg(OFF_RX_LEVEL, 32'h10, "rx level");
    rd_reg(OFF_IRQ_STATUS, 32'h3, "irq status");
    pin("irq", 1'b0);
    wr_reg(OFF_IRQ_ENABLE, 32'h2);
    pin("irq", 1'b1);
    wr_reg(OFF_IRQ_CLEAR, 32'h2);
    pin("irq", 1'b0);
    rd_reg(OFF_IRQ_STATUS, 32'h1, "irq status");
    for (int j = 0; j < 4; j++)
      rd_reg(OFF_RX_BUF, {22'h0, j[1:0], 8'ha0 + j[7:0]}, "rx head");
    rd_reg(OFF_STATUS, 32'h0e, "status");
    wr_reg(OFF_RX_LEVEL, 32'h5);
    rd_reg(OFF_RX_LEVEL, 32'hc, "rx level");
    wr_reg(OFF_SOFT_RESET, 32'h2);
    rd_reg(OFF_RX_LEVEL, 32'h0, "rx level");
    wr_reg(OFF_QUEUE_CTRL, 32'h0);
    wr_reg(OFF_RX_TWRITE, 32'h255);
    rd_reg(OFF_RX_BUF, 32'h255, "rx buffer");
    wr_reg(OFF_QUEUE_CTRL, 32'h1);
    for (int i = 0; i < 16; i++)
      wr_reg(OFF_TX_PUSH, 32'h50 + i);
    rd_reg(OFF_STATUS, 32'h0, "status");
    rd_reg(OFF_TX_LEVEL, 32'h10, "tx level");
    pin("valid", 32'h0);
    rd_reg(OFF_TX_READ, 32'h50, "tx read");
    wr_reg(OFF_TEST_ACCESS, 32'h0);
    @(posedge clk) pop <= 1'b1;
    @(posedge clk) pop <= 1'b0;
    rd_reg(OFF_TX_LEVEL, 32'he, "tx level");
    wr_reg(OFF_SOFT_RESET, 32'h4);
    rd_reg(OFF_STATUS, 32'h6, "status");
    wr_reg(OFF_TX_PUSH, 32'h3c);
    pin("valid", 32'h1);
    pin("tx data", 32'h3c);
    @(posedge clk) pop <= 1'b1;
    @(posedge clk) pop <= 1'b0;
    rd_reg(OFF_IRQ_STATUS, 32'h5, "irq status");
    pin("valid", 32'h0);
    wr_reg(OFF_RTS_ALIAS, 32'h1);
    rd_reg(OFF_MODEM_CTRL, 32'h2, "modem ctrl");
    pin("rts", 1'b0);
    wr_reg(OFF_MODEM_CTRL, 32'h0);
    rd_reg(OFF_RTS_ALIAS, 32'h0, "rts alias");
    wr_reg(OFF_RTS_ALIAS, 32'h1);
    wr_reg(OFF_TX_PUSH, 32'h1);
    wr_reg(OFF_SOFT_RESET, 32'h1);
    repeat (4) @(posedge clk);
    rd_reg(OFF_TX_LEVEL, 32'h0, "tx level");
    rd_reg(OFF_RTS_ALIAS, 32'h0, "rts alias");
    pin("rts", 1'b1);
    complete_run();
  end
endmodule // testbench
